//--- hw/gyf_pkg.sv
// Purpose: shared constants for the gyro conditioning path
// Assumes: byte-wide register port, 250 MHz core clock
// Notes: rate periods are whole core cycles, rounded down
package gyf_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] GYF_ADDR_Y_OFS_HI = 8'h15;
  localparam logic [7:0] GYF_ADDR_Y_OFS_LO = 8'h16;
  localparam logic [7:0] GYF_ADDR_Z_OFS_HI = 8'h17;
  localparam logic [7:0] GYF_ADDR_Z_OFS_LO = 8'h18;
  localparam logic [7:0] GYF_ADDR_RATE_DIV = 8'h19;
  localparam logic [7:0] GYF_ADDR_PATH_CFG = 8'h1A;

  localparam logic [7:0] GYF_CFG_RESET = 8'h80;
  localparam logic [7:0] GYF_ZERO_BYTE = 8'h00;
  localparam int GYF_CFG_FIFO_POLICY_BIT = 6;
  localparam int GYF_CFG_SYNC_SEL_LSB = 3;
  localparam int GYF_CFG_LPF_LSB = 0;

  localparam logic [2:0] GYF_LPF_WIDE = 3'h0;
  localparam logic [2:0] GYF_LPF_WIDE_HI = 3'h7;
  localparam logic [1:0] GYF_BYPASS_NONE = 2'h0;
  localparam logic [1:0] GYF_BYPASS_WIDE = 2'h2;

  // frame-sync destination codes
  localparam logic [2:0] GYF_SYNC_OFF = 3'h0;
  localparam logic [2:0] GYF_SYNC_TEMP = 3'h1;
  localparam logic [2:0] GYF_SYNC_GX = 3'h2;
  localparam logic [2:0] GYF_SYNC_GY = 3'h3;
  localparam logic [2:0] GYF_SYNC_GZ = 3'h4;
  localparam logic [2:0] GYF_SYNC_AX = 3'h5;
  localparam logic [2:0] GYF_SYNC_AY = 3'h6;
  localparam logic [2:0] GYF_SYNC_AZ = 3'h7;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int GYF_CLK_PERIOD_NS = 4;
  localparam int GYF_RATE_32K_NS = 31250;
  localparam int GYF_RATE_8K_NS = 125000;
  localparam int GYF_RATE_1K_NS = 1000000;
  localparam int GYF_RATE_32K_CYC = GYF_RATE_32K_NS / GYF_CLK_PERIOD_NS;
  localparam int GYF_RATE_8K_CYC = GYF_RATE_8K_NS / GYF_CLK_PERIOD_NS;
  localparam int GYF_RATE_1K_CYC = GYF_RATE_1K_NS / GYF_CLK_PERIOD_NS;
endpackage

//--- hw/gyf_axis.sv
// Purpose: offset add and one-pole low-pass for one channel
// Assumes: load pulses once per internal sample
// Notes: the offset sum saturates instead of wrapping
`timescale 1ns/1ns
`default_nettype none
module gyf_axis (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [15:0] raw,
  input wire logic [15:0] offset,
  input wire logic [2:0] shift,
  output logic [15:0] value_q
);
  logic signed [16:0] sum;
  logic signed [15:0] sat;
  logic signed [16:0] diff;
  logic signed [16:0] step;

  always_comb begin
    sum = $signed({raw[15], raw}) + $signed({offset[15], offset});
    if (sum > 17'sh07FFF) begin
      sat = 16'sh7FFF;
    end else if (sum < -17'sh08000) begin
      sat = -16'sh8000;
    end else begin
      sat = sum[15:0];
    end
    diff = $signed({sat[15], sat}) - $signed({value_q[15], value_q});
    step = diff >>> shift;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= 16'h0000;
    end else if (load) begin
      // shift 0 means the filter is bypassed
      value_q <= (shift == 3'h0) ? sat : 16'(value_q + step[15:0]);
    end
  end
endmodule
`default_nettype wire

//--- hw/gyf_sync_latch.sv
// Purpose: catch short frame-sync strobes for the sample strobe
// Assumes: pin is asynchronous to the core clock
// Notes: one toggle per output sample, later ones are ignored
`timescale 1ns/1ns
`default_nettype none
module gyf_sync_latch (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  input wire logic capture,
  output logic latched_q
);
  logic s1_q, s2_q, s3_q, level_q, armed_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= 1'b0;
      latched_q <= 1'b0;
      armed_q <= 1'b1;
    end else begin
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
      // a toggle in the capture cycle wins: the strobe takes the old value, the new one waits
      if ((armed_q || capture) && s2_q == s3_q && s3_q != level_q) begin
        latched_q <= ~latched_q; // RULE10
        armed_q <= 1'b0;
      end else if (capture) begin
        armed_q <= 1'b1; // RULE10
      end
    end
  end

  held_latch_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
    !armed_q && !capture |=> $stable(latched_q))
    else $error("latched sync changed while not armed");
endmodule
`default_nettype wire

//--- hw/gyf_top.sv
// Purpose: gyro offset, rate divider and path configuration
// Assumes: raw samples are valid whenever the internal tick fires
// Notes: bypass field comes from the gyro config register elsewhere
// Summary of operation
// RULE1: each gyro axis adds its signed 16-bit user offset before output; code has Y and Z offsets only, X adds zero.
// RULE2: offset high byte holds bits 15..8, low byte bits 7..0.
// RULE3: output rate is 1 kHz divided by one plus divider value.
// RULE4: divider acts only with bypass 00 and setting 1 to 6.
// RULE5: the divided rate also paces FIFO sample writes.
// RULE6: config bit 7 resets to 1; host should clear it.
// RULE7: policy bit 6 set and FIFO full drops new writes.
// RULE8: policy bit 6 clear and FIFO full overwrites oldest entry.
// RULE9: sync select 0 off; 1..7 picks temp, gyro, accel low bit.
// RULE10: sync latch toggles once, then waits for sample strobe capture.
// RULE11: low-pass setting bits 2..0 used only with bypass 00.
// RULE12: internal rate 32 kHz bypassed, 8 kHz at 0/7, else 1 kHz.
// RULE13: settings map to fixed bandwidths, widest at 0 and 7.
// RULE14: two-bit bypass field lives in another register.
// RULE15: new offsets and divider take effect at next internal sample.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module gyf_top #(
  parameter int RATE_32K_CYC = gyf_pkg::GYF_RATE_32K_CYC,
  parameter int RATE_8K_CYC = gyf_pkg::GYF_RATE_8K_CYC,
  parameter int RATE_1K_CYC = gyf_pkg::GYF_RATE_1K_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic [1:0] FILTER_BYPASS_FIELD,
  input wire logic FRAME_SYNC_INPUT,
  input wire logic [15:0] RAW_TEMP,
  input wire logic [15:0] RAW_ROT_X,
  input wire logic [15:0] RAW_ROT_Y,
  input wire logic [15:0] RAW_ROT_Z,
  input wire logic [15:0] RAW_ACCEL_X,
  input wire logic [15:0] RAW_ACCEL_Y,
  input wire logic [15:0] RAW_ACCEL_Z,
  output logic INTERNAL_TICK,
  output logic [2:0] RATE_SEL,
  output logic SAMPLE_STROBE,
  output logic [15:0] OUT_TEMP,
  output logic [15:0] OUT_ROT_X,
  output logic [15:0] OUT_ROT_Y,
  output logic [15:0] OUT_ROT_Z,
  output logic [15:0] OUT_ACCEL_X,
  output logic [15:0] OUT_ACCEL_Y,
  output logic [15:0] OUT_ACCEL_Z,
  input wire logic FIFO_FULL,
  output logic FIFO_WR,
  output logic FIFO_OVERWRITE
);
  import gyf_pkg::*;

  typedef enum logic [2:0] {RATE_32K, RATE_8K, RATE_1K} gyf_rate_e;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] ofs_y_q, ofs_z_q;
  logic [7:0] div_q, cfg_q;
  logic [7:0] rdata_q;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ofs_y_q <= 16'h0000;
      ofs_z_q <= 16'h0000;
      div_q <= 8'h00;
      cfg_q <= GYF_CFG_RESET; // RULE6
    end else if (REG_WR) begin
      if (REG_ADDR == GYF_ADDR_Y_OFS_HI) begin
        ofs_y_q[15:8] <= REG_WDATA; // RULE2
      end else if (REG_ADDR == GYF_ADDR_Y_OFS_LO) begin
        ofs_y_q[7:0] <= REG_WDATA; // RULE2
      end else if (REG_ADDR == GYF_ADDR_Z_OFS_HI) begin
        ofs_z_q[15:8] <= REG_WDATA; // RULE2
      end else if (REG_ADDR == GYF_ADDR_Z_OFS_LO) begin
        ofs_z_q[7:0] <= REG_WDATA; // RULE2
      end else if (REG_ADDR == GYF_ADDR_RATE_DIV) begin
        div_q <= REG_WDATA;
      end else if (REG_ADDR == GYF_ADDR_PATH_CFG) begin
        cfg_q <= REG_WDATA;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_q <= 8'h00;
    end else if (REG_RD) begin
      if (REG_ADDR == GYF_ADDR_Y_OFS_HI) begin
        rdata_q <= ofs_y_q[15:8];
      end else if (REG_ADDR == GYF_ADDR_Y_OFS_LO) begin
        rdata_q <= ofs_y_q[7:0];
      end else if (REG_ADDR == GYF_ADDR_Z_OFS_HI) begin
        rdata_q <= ofs_z_q[15:8];
      end else if (REG_ADDR == GYF_ADDR_Z_OFS_LO) begin
        rdata_q <= ofs_z_q[7:0];
      end else if (REG_ADDR == GYF_ADDR_RATE_DIV) begin
        rdata_q <= div_q;
      end else if (REG_ADDR == GYF_ADDR_PATH_CFG) begin
        rdata_q <= cfg_q;
      end else begin
        rdata_q <= GYF_ZERO_BYTE;
      end
    end else begin
      // data stands only in the cycle after the read
      rdata_q <= GYF_ZERO_BYTE;
    end
  end

  assign REG_RDATA = rdata_q;

  // ----------------------------------------
  // configuration decode
  // ----------------------------------------
  logic fifo_keep_old;
  logic [2:0] sync_sel;
  logic [2:0] lpf_set;
  logic filter_on;
  logic div_en;
  gyf_rate_e rate;

  assign fifo_keep_old = cfg_q[GYF_CFG_FIFO_POLICY_BIT];
  assign sync_sel = cfg_q[GYF_CFG_SYNC_SEL_LSB +: 3];
  assign lpf_set = cfg_q[GYF_CFG_LPF_LSB +: 3];
  assign filter_on = (FILTER_BYPASS_FIELD == GYF_BYPASS_NONE); // RULE11 RULE14
  assign div_en = filter_on && lpf_set != GYF_LPF_WIDE
    && lpf_set != GYF_LPF_WIDE_HI; // RULE4

  always_comb begin
    if (FILTER_BYPASS_FIELD[0] || FILTER_BYPASS_FIELD == GYF_BYPASS_WIDE) begin
      rate = RATE_32K; // RULE12
    end else if (!div_en) begin
      rate = RATE_8K; // RULE12
    end else begin
      rate = RATE_1K; // RULE12
    end
  end

  assign RATE_SEL = rate;

  // filter pole per setting; a narrower band is a larger shift
  logic [2:0] shift;

  always_comb begin
    shift = 3'h0;
    if (filter_on) begin
      case (lpf_set)
        3'h1: shift = 3'h2; // RULE13
        3'h2: shift = 3'h3; // RULE13
        3'h3: shift = 3'h4; // RULE13
        3'h4: shift = 3'h5; // RULE13
        3'h5: shift = 3'h6; // RULE13
        3'h6: shift = 3'h7; // RULE13
        default: shift = 3'h1; // RULE13
      endcase
    end
  end

  // ----------------------------------------
  // internal sample tick
  // ----------------------------------------
  logic [17:0] tick_cnt_q;
  logic [17:0] period_m1;
  logic tick;

  always_comb begin
    case (rate)
      RATE_32K: period_m1 = 18'(RATE_32K_CYC - 1);
      RATE_8K: period_m1 = 18'(RATE_8K_CYC - 1);
      default: period_m1 = 18'(RATE_1K_CYC - 1);
    endcase
  end

  // a rate change that lowers the period ends the current one early
  assign tick = (tick_cnt_q >= period_m1);

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tick_cnt_q <= 18'h00000;
    end else if (tick) begin
      tick_cnt_q <= 18'h00000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 18'h00001;
    end
  end

  assign INTERNAL_TICK = tick;

  // ----------------------------------------
  // shadow copies, loaded between samples
  // ----------------------------------------
  logic [15:0] ofs_y_sh_q, ofs_z_sh_q;
  logic [7:0] div_sh_q;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ofs_y_sh_q <= 16'h0000;
      ofs_z_sh_q <= 16'h0000;
      div_sh_q <= 8'h00;
    end else if (tick) begin
      ofs_y_sh_q <= ofs_y_q; // RULE15
      ofs_z_sh_q <= ofs_z_q; // RULE15
      div_sh_q <= div_q; // RULE15
    end
  end

  // ----------------------------------------
  // rate divider
  // ----------------------------------------
  logic [7:0] div_cnt_q;
  logic strobe;

  assign strobe = tick && (!div_en || div_cnt_q >= div_sh_q); // RULE3 RULE4

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      div_cnt_q <= 8'h00;
    end else if (tick) begin
      div_cnt_q <= strobe ? 8'h00 : div_cnt_q + 8'h01; // RULE3
    end
  end

  assign SAMPLE_STROBE = strobe;

  // ----------------------------------------
  // channel conditioning
  // ----------------------------------------
  logic [15:0] f_temp, f_gx, f_gy, f_gz;

  gyf_axis u_temp (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .load(tick),
    .raw(RAW_TEMP),
    .offset(16'h0000),
    .shift(shift),
    .value_q(f_temp)
  );

  gyf_axis u_gx (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .load(tick),
    .raw(RAW_ROT_X),
    .offset(16'h0000),
    .shift(shift),
    .value_q(f_gx)
  );

  gyf_axis u_gy (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .load(tick),
    .raw(RAW_ROT_Y),
    .offset(ofs_y_sh_q), // RULE1
    .shift(shift),
    .value_q(f_gy)
  );

  gyf_axis u_gz (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .load(tick),
    .raw(RAW_ROT_Z),
    .offset(ofs_z_sh_q), // RULE1
    .shift(shift),
    .value_q(f_gz)
  );

  // ----------------------------------------
  // frame sync
  // ----------------------------------------
  logic sync_bit;

  gyf_sync_latch u_sync (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .pin(FRAME_SYNC_INPUT),
    .capture(strobe),
    .latched_q(sync_bit)
  );

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  function automatic logic [15:0] tag_lsb(input logic [15:0] v, input logic hit, input logic b);
    tag_lsb = hit ? {v[15:1], b} : v;
  endfunction

  // filtered values lag by one cycle, so outputs use the held copies
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      OUT_TEMP <= 16'h0000;
      OUT_ROT_X <= 16'h0000;
      OUT_ROT_Y <= 16'h0000;
      OUT_ROT_Z <= 16'h0000;
      OUT_ACCEL_X <= 16'h0000;
      OUT_ACCEL_Y <= 16'h0000;
      OUT_ACCEL_Z <= 16'h0000;
    end else if (strobe) begin
      OUT_TEMP <= tag_lsb(f_temp, sync_sel == GYF_SYNC_TEMP, sync_bit); // RULE9
      OUT_ROT_X <= tag_lsb(f_gx, sync_sel == GYF_SYNC_GX, sync_bit); // RULE9
      OUT_ROT_Y <= tag_lsb(f_gy, sync_sel == GYF_SYNC_GY, sync_bit); // RULE9
      OUT_ROT_Z <= tag_lsb(f_gz, sync_sel == GYF_SYNC_GZ, sync_bit); // RULE9
      OUT_ACCEL_X <= tag_lsb(RAW_ACCEL_X, sync_sel == GYF_SYNC_AX, sync_bit); // RULE9
      OUT_ACCEL_Y <= tag_lsb(RAW_ACCEL_Y, sync_sel == GYF_SYNC_AY, sync_bit); // RULE9
      OUT_ACCEL_Z <= tag_lsb(RAW_ACCEL_Z, sync_sel == GYF_SYNC_AZ, sync_bit); // RULE9
    end
  end

  // ----------------------------------------
  // FIFO write policy
  // ----------------------------------------
  assign FIFO_WR = strobe && !(FIFO_FULL && fifo_keep_old); // RULE5 RULE7
  assign FIFO_OVERWRITE = strobe && FIFO_FULL && !fifo_keep_old; // RULE8

  // ----------------------------------------
  // checks
  // ----------------------------------------
  fifo_drop_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE7
    strobe && FIFO_FULL && fifo_keep_old |-> !FIFO_WR && !FIFO_OVERWRITE)
    else $error("write not dropped with full fifo");

  fifo_overwrite_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE8
    strobe && FIFO_FULL && !fifo_keep_old |-> FIFO_WR && FIFO_OVERWRITE)
    else $error("oldest entry not overwritten");

  fifo_pace_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE5
    FIFO_WR |-> strobe)
    else $error("fifo write off the sample strobe");

  div_ignored_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE4
    tick && !div_en |-> strobe)
    else $error("divider acted while bypassed");

  div_count_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE3
    tick && div_en && div_cnt_q < div_sh_q |-> !strobe ##1 div_cnt_q == $past(div_cnt_q) + 8'h01)
    else $error("divider fired early");

  out_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE3
    !strobe |=> $stable(OUT_ROT_Y) && $stable(OUT_TEMP))
    else $error("outputs moved without strobe");

  shadow_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE15
    !tick |=> $stable(ofs_y_sh_q) && $stable(div_sh_q))
    else $error("shadow changed mid sample");

  offset_byte_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE2
    REG_WR && REG_ADDR == GYF_ADDR_Z_OFS_HI |=> ofs_z_q[15:8] == $past(REG_WDATA))
    else $error("offset high byte not stored");

  sync_place_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE9
    strobe && sync_sel == GYF_SYNC_GZ |=> OUT_ROT_Z[0] == $past(sync_bit))
    else $error("sync bit misplaced");

  rate_pick_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE12
    FILTER_BYPASS_FIELD[0] |-> rate == RATE_32K)
    else $error("bypass did not select fastest rate");
endmodule
`default_nettype wire

//--- bench/gyf_host_model.sv
// Purpose: host processor model on the register port
// Assumes: strobes are launched just after a rising edge
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/1ns
`default_nettype none
module gyf_host_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  import gyf_pkg::*;
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  initial begin
    addr = GYF_ZERO_BYTE;
    wdata = GYF_ZERO_BYTE;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  // read data stands only in the cycle after the strobe, so it is taken there
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(negedge clk);
    d = rdata;
  endtask
  // setup always clears the power-on bit 7
  task automatic setup_path(input logic [6:0] cfg);
    write_reg(GYF_ADDR_PATH_CFG, {1'b0, cfg});
  endtask
endmodule
`default_nettype wire

//--- bench/tb_gyf_top.sv
// Purpose: self-checking bench for the gyro offset, rate and path block
// Assumes: short rate periods so every mode runs in a few cycles
// Notes: outputs are read at the falling edge, after the rising edge updates land
`timescale 1ns/1ns
`default_nettype none
module tb_gyf_top;
  import gyf_pkg::*;
  localparam int P32 = 8;
  localparam int P8 = 16;
  localparam int P1 = 32;
  localparam logic [15:0] RAW_SET [7] = '{16'h0100, 16'h0200, 16'h1000, 16'h0010, 16'h0400, 16'h0800, 16'h2000};
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] bypass = 2'h0;
  logic frame_sync_input = 1'b0;
  logic fifo_full = 1'b0;
  logic [15:0] raw_v [7];
  wire [15:0] out_v [7];
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, tick, strobe, fifo_wr, fifo_ovw;
  wire [2:0] rate_sel;
  int miscompares = 0;
  int samples_checked = 0;

  always #2 core_clk = ~core_clk;

  gyf_host_model u_host (.clk(core_clk), .rdata(reg_rdata), .addr(reg_addr), .wdata(reg_wdata), .wr(reg_wr),
    .rd(reg_rd));
  gyf_top #(.RATE_32K_CYC(P32), .RATE_8K_CYC(P8), .RATE_1K_CYC(P1)) u_dut (
    .CORE_CLK(core_clk), .RESETN(resetn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .FILTER_BYPASS_FIELD(bypass), .FRAME_SYNC_INPUT(frame_sync_input),
    .RAW_TEMP(raw_v[0]), .RAW_ROT_X(raw_v[1]), .RAW_ROT_Y(raw_v[2]), .RAW_ROT_Z(raw_v[3]),
    .RAW_ACCEL_X(raw_v[4]), .RAW_ACCEL_Y(raw_v[5]), .RAW_ACCEL_Z(raw_v[6]), .INTERNAL_TICK(tick),
    .RATE_SEL(rate_sel), .SAMPLE_STROBE(strobe), .OUT_TEMP(out_v[0]), .OUT_ROT_X(out_v[1]),
    .OUT_ROT_Y(out_v[2]), .OUT_ROT_Z(out_v[3]), .OUT_ACCEL_X(out_v[4]), .OUT_ACCEL_Y(out_v[5]),
    .OUT_ACCEL_Z(out_v[6]), .FIFO_FULL(fifo_full), .FIFO_WR(fifo_wr), .FIFO_OVERWRITE(fifo_ovw));

  // ----------------------------------------
  // compares and waits
  // ----------------------------------------
  task automatic fail(input string msg);
    miscompares++;
    $display("CHECK FAILED %0t %s", $time, msg);
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) fail("byte mismatch");
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) fail("sample word mismatch");
  endtask
  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) fail("flag mismatch");
  endtask
  task automatic chk_cnt(input int got, input int exp);
    samples_checked++;
    if (got != exp) fail("tick count mismatch");
  endtask
  task automatic results();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // bounded so a dead strobe is reported instead of hanging
  task automatic next_strobe();
    int n;
    n = 0;
    @(negedge core_clk);
    while (strobe !== 1'b1 && n < 10000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 10000) fail("no sample strobe");
  endtask
  task automatic ticks_between(output int t);
    next_strobe();
    t = 0;
    do begin
      @(negedge core_clk);
      if (tick === 1'b1) t++;
    end while (strobe !== 1'b1 && t < 300);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [7:0] d;
    @(negedge core_clk);
    chk8({5'h0, rate_sel}, 8'h01);
    for (int i = 0; i < 6; i++) begin
      u_host.read_reg(GYF_ADDR_Y_OFS_HI + 8'(i), d);
      chk8(d, (i == 5) ? GYF_CFG_RESET : GYF_ZERO_BYTE);
      u_host.write_reg(GYF_ADDR_Y_OFS_HI + 8'(i), {4'hA, 4'(i)});
      u_host.read_reg(GYF_ADDR_Y_OFS_HI + 8'(i), d);
      chk8(d, {4'hA, 4'(i)});
    end
    u_host.write_reg(8'h14, 8'h5A);
    u_host.read_reg(8'h14, d);
    chk8(d, GYF_ZERO_BYTE);
  endtask
  task automatic t_rates();
    logic [7:0] e;
    for (int b = 0; b < 4; b++) begin
      for (int s = 0; s < 8; s++) begin
        @(posedge core_clk);
        bypass <= 2'(b);
        u_host.setup_path(7'(s));
        @(negedge core_clk);
        e = (b[0] || b == 2) ? 8'h00 : ((s == 0 || s == 7) ? 8'h01 : 8'h02);
        chk8({5'h0, rate_sel}, e);
      end
    end
  endtask
  task automatic t_divider();
    int t;
    @(posedge core_clk);
    bypass <= 2'h0;
    u_host.write_reg(GYF_ADDR_RATE_DIV, 8'h02);
    u_host.setup_path(7'h01);
    ticks_between(t);
    ticks_between(t);
    chk_cnt(t, 3);
    u_host.write_reg(GYF_ADDR_RATE_DIV, 8'hFF);
    ticks_between(t);
    ticks_between(t);
    chk_cnt(t, 256);
    u_host.setup_path(7'h00);
    u_host.write_reg(GYF_ADDR_RATE_DIV, 8'h02);
    for (int k = 0; k < 3; k++) begin
      @(posedge core_clk);
      bypass <= (k == 2) ? 2'h2 : 2'h0;
      u_host.setup_path((k == 0) ? 7'h00 : ((k == 1) ? 7'h07 : 7'h01));
      ticks_between(t);
      ticks_between(t);
      chk_cnt(t, 1);
    end
  endtask
  task automatic t_offset();
    @(posedge core_clk);
    bypass <= 2'h1;
    for (int i = 0; i < 7; i++) begin
      raw_v[i] <= RAW_SET[i];
    end
    u_host.setup_path(7'h00);
    u_host.write_reg(GYF_ADDR_Y_OFS_HI, 8'h01);
    u_host.write_reg(GYF_ADDR_Y_OFS_LO, 8'h00);
    u_host.write_reg(GYF_ADDR_Z_OFS_HI, 8'hFF);
    u_host.write_reg(GYF_ADDR_Z_OFS_LO, 8'hFE);
    repeat (4) next_strobe();
    chk16(out_v[2], 16'h1100);
    chk16(out_v[3], 16'h000E);
    for (int i = 0; i < 7; i++) begin
      if (i != 2 && i != 3) begin
        chk16(out_v[i], RAW_SET[i]);
      end
    end
  endtask
  task automatic t_fifo();
    for (int p = 0; p < 2; p++) begin
      for (int f = 0; f < 2; f++) begin
        @(posedge core_clk);
        fifo_full <= f[0];
        u_host.setup_path({p[0], 6'h00});
        next_strobe();
        chk1(fifo_wr, !(f[0] && p[0]));
        chk1(fifo_ovw, f[0] && !p[0]);
        @(negedge core_clk);
        chk1(fifo_wr, 1'b0);
      end
    end
    @(posedge core_clk);
    fifo_full <= 1'b0;
  endtask
  // a pulse whose both edges fall inside one output interval must still read as one toggle
  task automatic t_sync();
    @(posedge core_clk);
    bypass <= 2'h1;
    u_host.setup_path({1'b0, GYF_SYNC_GY, 3'h0});
    next_strobe();
    @(posedge core_clk);
    frame_sync_input <= 1'b1;
    repeat (2) @(posedge core_clk);
    frame_sync_input <= 1'b0;
    repeat (2) next_strobe();
    chk1(out_v[2][0], 1'b1);
    for (int s = 0; s < 8; s++) begin
      u_host.setup_path({1'b0, 3'(s), 3'h0});
      repeat (2) next_strobe();
      for (int j = 0; j < 7; j++) begin
        chk1(out_v[j][0], (s == j + 1) ? 1'b1 : 1'b0);
      end
    end
  endtask

  initial begin
    for (int i = 0; i < 7; i++) begin
      raw_v[i] = 16'h0000;
    end
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs();
    t_rates();
    t_divider();
    t_offset();
    t_fifo();
    t_sync();
    results();
  end
  // the long divider case dominates, about 33k cycles
  initial begin
    #300000;
    fail("watchdog expired");
    results();
  end
endmodule
`default_nettype wire
